// ---- rtl/scss_map.svh ----
`ifndef SCSS_MAP_SVH
`define SCSS_MAP_SVH
// ****************************************
// register byte addresses
// ****************************************
`define SCSS_ADDR_CTRL 16'h1C00
`define SCSS_ADDR_CLKCFG 16'h1C04
`define SCSS_ADDR_STATUS 16'h1C08
`define SCSS_ADDR_PULL2 16'h1C18
// ****************************************
// field positions
// ****************************************
`define SCSS_CTRL_CLOCK_OUTPUT_OFF 0
`define SCSS_CTRL_OSC 1
`define SCSS_CTRL_LDO 2
`define SCSS_CFG_SRC_LO 0
`define SCSS_CFG_SRC_HI 1
`define SCSS_PULL_EXTERNAL_CLOCK_INPUT 0
`define SCSS_ST_SEL 0
`define SCSS_ST_OSC 1
`define SCSS_ST_LDO 2
`define SCSS_ST_DRIVEN 3
`define SCSS_ST_EXTERNAL_CLOCK_INPUT_PD 4
// ****************************************
// reset values
// ****************************************
`define SCSS_RST_CTRL 16'h0000
`define SCSS_RST_CLKCFG 16'h0000
`define SCSS_RST_PULL2 16'h0001
`endif

// ---- rtl/scss_pkg.sv ----
// ****************************************
// shared types
// ****************************************
package scss_pkg;
	// apb request from the master
	typedef struct packed {
		logic psel; // slave select
		logic penable; // access phase
		logic pwrite; // 1 = write
		logic [15:0] paddr; // byte address
		logic [31:0] pwdata; // write data
	} scss_apb_req_t;
	// which clock is tapped onto the debug pin
	typedef enum logic [1:0] {
		SCSS_SRC_SYSGEN,
		SCSS_SRC_OSC,
		SCSS_SRC_EXT,
		SCSS_SRC_DIV2
	} scss_src_t;
	// strap capture sequence
	typedef enum logic {
		SCSS_ST_CAPTURE,
		SCSS_ST_RUN
	} scss_state_t;
endpackage : scss_pkg

// ---- rtl/scss_clock_source_select.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scss_map.svh"

module scss_clock_source_select (
	input wire logic sys_clk_i, // 40 mhz system clock
	input wire logic reset_n_i, // async reset, low
	input wire scss_pkg::scss_apb_req_t apb_req_i, // apb request
	output logic [31:0] prdata_o, // apb read data
	output logic pready_o, // apb ready
	output logic pslverr_o, // apb error
	input wire logic clk_sel_i, // clock select strap pin
	input wire logic external_clock_input_i, // external clock pin
	input wire logic osc_clock_i, // on-chip oscillator
	output logic ext_clk_selected_o, // sysgen from ext pin
	output logic osc_enable_o, // oscillator enable
	output logic usb_regulator_enable_o, // regulator enable
	output logic debug_clock_output_o, // debug pin data
	output logic debug_clock_output_oe_o, // debug pin drive
	output logic debug_clock_pulldown_o, // debug pin pulldown
	output logic external_clock_input_pulldown_o // ext pin pulldown
);
	import scss_pkg::*;

	// ****************************************
	// input synchronisers
	// ****************************************
	// bit 0 strap, bit 1 ext clock, bit 2 osc
	logic [2:0] sync_a_ff; // first stage
	logic [2:0] sync_b_ff; // second stage
	logic [2:0] nxt_sync_a; // first stage next
	logic [2:0] nxt_sync_b; // second stage next

	// two stages; first read only by second
	always_comb begin
		nxt_sync_a = {osc_clock_i, external_clock_input_i, clk_sel_i};
		nxt_sync_b = sync_a_ff;
	end

	// register the synchroniser stages
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync_a_ff <= 3'h0;
			sync_b_ff <= 3'h0;
		end else begin
			sync_a_ff <= nxt_sync_a;
			sync_b_ff <= nxt_sync_b;
		end
	end

	// ****************************************
	// strap capture
	// ****************************************
	scss_state_t state_ff; // capture or run
	scss_state_t nxt_state; // state next
	logic sel_ff; // latched select
	logic nxt_sel; // latched select next
	logic [1:0] wait_ff; // settle counter
	logic [1:0] nxt_wait; // settle counter next
	logic settled; // strap sample valid

	// strap taken once after release; a pin
	// change later must not glitch sysgen
	always_comb begin
		nxt_state = state_ff;
		nxt_sel = sel_ff;
		unique case (state_ff)
			SCSS_ST_CAPTURE: begin
				// second stage holds the pin only once
				// the settle counter has run out
				if (settled) begin
					nxt_sel = sync_b_ff[0];
					nxt_state = SCSS_ST_RUN;
				end
			end
			SCSS_ST_RUN: begin
				// hold; pin ignored from here
				nxt_sel = sel_ff;
			end
		endcase
	end

	// register capture state
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_ff <= SCSS_ST_CAPTURE;
			sel_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			sel_ff <= nxt_sel;
		end
	end

	// ****************************************
	// capture delay
	// ****************************************
	// two idle cycles so the strap sample
	// has crossed both synchroniser stages

	// count up to settle, then stop
	always_comb begin
		settled = (wait_ff == 2'h2);
		nxt_wait = wait_ff;
		if (!settled) begin
			nxt_wait = wait_ff + 2'h1;
		end
	end

	// register settle counter
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wait_ff <= 2'h0;
		end else begin
			wait_ff <= nxt_wait;
		end
	end

	// ****************************************
	// apb decode
	// ****************************************
	logic access; // access phase seen
	logic wr_en; // write takes effect
	logic hit_ctrl; // control selected
	logic hit_cfg; // config selected
	logic hit_status; // status selected
	logic hit_pull; // pull reg selected
	logic hit_any; // mapped address

	// decode full byte address
	always_comb begin
		access = apb_req_i.psel & apb_req_i.penable;
		hit_ctrl = (apb_req_i.paddr == `SCSS_ADDR_CTRL);
		hit_cfg = (apb_req_i.paddr == `SCSS_ADDR_CLKCFG);
		hit_status = (apb_req_i.paddr == `SCSS_ADDR_STATUS);
		hit_pull = (apb_req_i.paddr == `SCSS_ADDR_PULL2);
		hit_any = hit_ctrl | hit_cfg | hit_status | hit_pull;
		wr_en = access & pready_o & apb_req_i.pwrite & hit_any;
	end

	// ****************************************
	// software registers
	// ****************************************
	logic [15:0] ctrl_ff; // clock-off, osc, ldo
	logic [15:0] cfg_ff; // debug source select
	logic [15:0] pull_ff; // pull inhibit bits
	logic [15:0] nxt_ctrl; // control next
	logic [15:0] nxt_cfg; // config next
	logic [15:0] nxt_pull; // pull next
	logic run_sel; // select valid and high

	// writes land on the completing edge
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_cfg = cfg_ff;
		nxt_pull = pull_ff;
		run_sel = sel_ff & (state_ff == SCSS_ST_RUN);
		if (wr_en && hit_ctrl) begin
			nxt_ctrl = {13'h0000, apb_req_i.pwdata[2:0]};
		end
		if (wr_en && hit_cfg) begin
			nxt_cfg = {14'h0000, apb_req_i.pwdata[1:0]};
		end
		if (wr_en && hit_pull) begin
			nxt_pull = apb_req_i.pwdata[15:0];
		end
		// internal source latched: enables forced on,
		// so a software clear is ignored; nothing is
		// forced before capture, so select high starts off
		if ((state_ff == SCSS_ST_RUN) && !sel_ff) begin
			nxt_ctrl[`SCSS_CTRL_OSC] = 1'b1;
			nxt_ctrl[`SCSS_CTRL_LDO] = 1'b1;
		end
	end

	// register software state
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_ff <= `SCSS_RST_CTRL;
			cfg_ff <= `SCSS_RST_CLKCFG;
			pull_ff <= `SCSS_RST_PULL2;
		end else begin
			ctrl_ff <= nxt_ctrl;
			cfg_ff <= nxt_cfg;
			pull_ff <= nxt_pull;
		end
	end

	// ****************************************
	// apb answer
	// ****************************************
	logic [31:0] nxt_prdata; // read data next
	logic nxt_pready; // ready next
	logic nxt_pslverr; // error next
	logic [15:0] status; // live status word

	// one wait state, then ready for a cycle
	always_comb begin
		status = 16'h0000;
		status[`SCSS_ST_SEL] = ext_clk_selected_o;
		status[`SCSS_ST_OSC] = osc_enable_o;
		status[`SCSS_ST_LDO] = usb_regulator_enable_o;
		status[`SCSS_ST_DRIVEN] = debug_clock_output_oe_o;
		status[`SCSS_ST_EXTERNAL_CLOCK_INPUT_PD] = external_clock_input_pulldown_o;
		nxt_pready = access & ~pready_o;
		nxt_pslverr = access & ~pready_o & ~hit_any;
		nxt_prdata = 32'h0000_0000;
		if (access && !pready_o && !apb_req_i.pwrite) begin
			unique case (1'b1)
				hit_ctrl: nxt_prdata = {16'h0000, ctrl_ff};
				hit_cfg: nxt_prdata = {16'h0000, cfg_ff};
				hit_status: nxt_prdata = {16'h0000, status};
				hit_pull: nxt_prdata = {16'h0000, pull_ff};
				default: nxt_prdata = 32'h0000_0000;
			endcase
		end
	end

	// register apb answer
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			prdata_o <= nxt_prdata;
			pready_o <= nxt_pready;
			pslverr_o <= nxt_pslverr;
		end
	end

	// ****************************************
	// clock tap
	// ****************************************
	logic div_ff; // sys clock divided by two
	logic nxt_div; // divider next
	logic tap; // selected clock sample
	scss_src_t src; // debug source field

	// pick the tapped clock
	always_comb begin
		nxt_div = ~div_ff;
		src = scss_src_t'(cfg_ff[`SCSS_CFG_SRC_HI:`SCSS_CFG_SRC_LO]);
		unique case (src)
			SCSS_SRC_SYSGEN: tap = run_sel ? sync_b_ff[1] : sync_b_ff[2];
			SCSS_SRC_OSC: tap = sync_b_ff[2];
			SCSS_SRC_EXT: tap = sync_b_ff[1];
			SCSS_SRC_DIV2: tap = div_ff;
		endcase
	end

	// register divider
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
		end
	end

	// ****************************************
	// pin control
	// ****************************************
	logic nxt_ext_sel; // sysgen source next
	logic nxt_osc_en; // oscillator next
	logic nxt_ldo_en; // regulator next
	logic nxt_dbg; // debug data next
	logic nxt_dbg_oe; // debug drive next
	logic nxt_dbg_pd; // debug pulldown next
	logic nxt_ext_pd; // ext pulldown next

	// pins follow registers one cycle later;
	// sample-based tap, so only a debug aid
	always_comb begin
		nxt_ext_sel = run_sel;
		// select high: software owns enables
		nxt_osc_en = ~run_sel | ctrl_ff[`SCSS_CTRL_OSC];
		nxt_ldo_en = ~run_sel | ctrl_ff[`SCSS_CTRL_LDO];
		nxt_dbg_oe = ~ctrl_ff[`SCSS_CTRL_CLOCK_OUTPUT_OFF];
		nxt_dbg_pd = ctrl_ff[`SCSS_CTRL_CLOCK_OUTPUT_OFF];
		nxt_dbg = nxt_dbg_oe & tap;
		nxt_ext_pd = ~pull_ff[`SCSS_PULL_EXTERNAL_CLOCK_INPUT];
	end

	// register pin controls
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ext_clk_selected_o <= 1'b0;
			osc_enable_o <= 1'b1;
			usb_regulator_enable_o <= 1'b1;
			debug_clock_output_o <= 1'b0;
			debug_clock_output_oe_o <= 1'b1;
			debug_clock_pulldown_o <= 1'b0;
			external_clock_input_pulldown_o <= 1'b0;
		end else begin
			ext_clk_selected_o <= nxt_ext_sel;
			osc_enable_o <= nxt_osc_en;
			usb_regulator_enable_o <= nxt_ldo_en;
			debug_clock_output_o <= nxt_dbg;
			debug_clock_output_oe_o <= nxt_dbg_oe;
			debug_clock_pulldown_o <= nxt_dbg_pd;
			external_clock_input_pulldown_o <= nxt_ext_pd;
		end
	end

endmodule : scss_clock_source_select
`default_nettype wire

// ---- verification/scss_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scss_map.svh"
// ****************
// pin and bus checks
// ****************
module scss_monitor (
	input wire logic sys_clk_i, // clock
	input wire logic reset_n_i, // reset, low
	input wire scss_pkg::scss_apb_req_t apb_req_i, // request
	input wire logic [31:0] prdata_o, // read data
	input wire logic pready_o, // ready
	input wire logic pslverr_o, // error
	input wire logic clk_sel_i, // strap
	input wire logic external_clock_input_i, // ext pin
	input wire logic osc_clock_i, // osc
	input wire logic ext_clk_selected_o, // ext used
	input wire logic osc_enable_o, // osc on
	input wire logic usb_regulator_enable_o, // ldo on
	input wire logic debug_clock_output_o, // dbg data
	input wire logic debug_clock_output_oe_o, // dbg drive
	input wire logic debug_clock_pulldown_o, // dbg pd
	input wire logic external_clock_input_pulldown_o // ext pd
);
	import scss_pkg::*;
	logic acc; // access phase
	logic wr_ok; // write lands
	logic mapped; // known address
	logic [3:0] age_ff; // cycles since reset
	logic [3:0] nxt_age; // saturating
	assign acc = apb_req_i.psel && apb_req_i.penable;
	assign wr_ok = acc && pready_o && apb_req_i.pwrite;
	assign mapped = apb_req_i.paddr inside {`SCSS_ADDR_CTRL, `SCSS_ADDR_CLKCFG,
		`SCSS_ADDR_STATUS, `SCSS_ADDR_PULL2};
	// age gates strap checks until the strap has settled
	always_comb begin
		nxt_age = (age_ff == 4'hF) ? age_ff : age_ff + 4'h1;
	end
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			age_ff <= 4'h0;
		end else begin
			age_ff <= nxt_age;
		end
	end
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	chk_pd_tracks: assert property (debug_clock_pulldown_o == !debug_clock_output_oe_o)
		else $error("debug pulldown not opposite drive");
	chk_oe_write: assert property ((wr_ok && apb_req_i.paddr == `SCSS_ADDR_CTRL) |->
		##2 (debug_clock_output_oe_o == !$past(apb_req_i.pwdata[0], 2)))
		else $error("debug drive does not follow off bit");
	chk_pull_write: assert property ((wr_ok && apb_req_i.paddr == `SCSS_ADDR_PULL2) |->
		##2 (external_clock_input_pulldown_o == !$past(apb_req_i.pwdata[0], 2)))
		else $error("ext pulldown does not follow register");
	chk_apb_wait: assert property ((acc && !pready_o) |=> pready_o)
		else $error("ready late");
	chk_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("ready longer than one cycle");
	chk_bad_addr: assert property ((acc && pready_o) |-> (pslverr_o == !mapped))
		else $error("error flag wrong for address");
	chk_sel_low: assert property ((age_ff > 4'h6 && !ext_clk_selected_o) |->
		(osc_enable_o && usb_regulator_enable_o))
		else $error("osc or ldo off with select low");
	chk_sel_static: assert property ((age_ff > 4'h6) |-> $stable(ext_clk_selected_o))
		else $error("clock source moved after capture");
	cover property (wr_ok && apb_req_i.paddr == `SCSS_ADDR_CTRL);
	cover property (acc && pready_o && pslverr_o);
	cover property (age_ff > 4'h6 && ext_clk_selected_o);
endmodule : scss_monitor
bind scss_clock_source_select scss_monitor u_scss_monitor (.sys_clk_i(sys_clk_i),
	.reset_n_i(reset_n_i), .apb_req_i(apb_req_i), .prdata_o(prdata_o), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .clk_sel_i(clk_sel_i), .osc_clock_i(osc_clock_i),
	.external_clock_input_i(external_clock_input_i), .ext_clk_selected_o(ext_clk_selected_o),
	.osc_enable_o(osc_enable_o), .usb_regulator_enable_o(usb_regulator_enable_o),
	.debug_clock_output_o(debug_clock_output_o),
	.debug_clock_output_oe_o(debug_clock_output_oe_o),
	.debug_clock_pulldown_o(debug_clock_pulldown_o),
	.external_clock_input_pulldown_o(external_clock_input_pulldown_o));
`default_nettype wire

// ---- verification/scss_clk_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************
// clock sources at the far pins
// ****************
module scss_clk_model (
	output logic ext_clk_o, // external clock pin
	output logic osc_clk_o // on-chip oscillator
);
	// board clock, free running, unrelated to the system clock
	initial begin
		ext_clk_o = 1'h0;
		forever #19 ext_clk_o = ~ext_clk_o;
	end
	// 12 mhz oscillator, never pauses
	initial begin
		osc_clk_o = 1'h0;
		forever #41.667 osc_clk_o = ~osc_clk_o;
	end
endmodule : scss_clk_model
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scss_map.svh"
// ****************
// bench
// ****************
module tb;
	import scss_pkg::*;
	logic sys_clk_i, reset_n_i, rdy, err, sel, ext_clk, osc_clk; // bus and pins
	logic ext_sel, osc_en, ldo_en, dbg, dbg_oe, dbg_pd, ext_pd; // outputs
	scss_apb_req_t req; // apb request
	logic [31:0] rd, q; // read data
	logic e; // taken error
	int bad_count, samples_checked, i;
	scss_clock_source_select u_scss_clock_source_select (.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i), .apb_req_i(req), .prdata_o(rd), .pready_o(rdy),
		.pslverr_o(err), .clk_sel_i(sel), .external_clock_input_i(ext_clk),
		.osc_clock_i(osc_clk), .ext_clk_selected_o(ext_sel), .osc_enable_o(osc_en),
		.usb_regulator_enable_o(ldo_en), .debug_clock_output_o(dbg),
		.debug_clock_output_oe_o(dbg_oe), .debug_clock_pulldown_o(dbg_pd),
		.external_clock_input_pulldown_o(ext_pd));
	scss_clk_model u_scss_clk_model (.ext_clk_o(ext_clk), .osc_clk_o(osc_clk));
	initial begin
		sys_clk_i = 1'h0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	task ck(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x) begin
			bad_count++;
			$display("unexpected at %0t got %h exp %h", $time, g, x);
		end
	endtask : ck
	// one apb transfer; request held until ready seen at an edge
	task xfer(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		req <= '{1'h1, 1'h0, w, a, d};
		@(posedge sys_clk_i);
		req.penable <= 1'h1;
		// wait for ready; only the watchdog ends a hang
		@(posedge sys_clk_i);
		while (rdy !== 1'h1) begin
			@(posedge sys_clk_i);
		end
		q = rd;
		e = err;
		req.psel <= 1'h0;
		req.penable <= 1'h0;
	endtask : xfer
	// strap is set before reset and held through capture
	task rst(input logic s);
		sel <= s;
		reset_n_i <= 1'h0;
		repeat (2) @(posedge sys_clk_i);
		reset_n_i <= 1'h1;
		repeat (6) @(posedge sys_clk_i);
	endtask : rst
	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_sim
	initial begin
		#50000;
		bad_count++;
		end_sim;
	end
	initial begin
		req = '0;
		sel = 1'h0;
		reset_n_i = 1'h0;
		rst(1'h0);
		ck({ext_sel, osc_en, ldo_en}, 3'h3);
		ck({dbg_oe, dbg_pd, ext_pd}, 3'h4);
		xfer(1'h0, `SCSS_ADDR_PULL2, 32'h0);
		ck(q, 32'h1);
		xfer(1'h1, `SCSS_ADDR_CTRL, 32'h0);
		repeat (2) @(posedge sys_clk_i);
		ck({osc_en, ldo_en}, 2'h3);
		xfer(1'h0, `SCSS_ADDR_CTRL, 32'h0);
		ck(q, 32'h6);
		xfer(1'h1, `SCSS_ADDR_CTRL, 32'h1);
		repeat (2) @(posedge sys_clk_i);
		ck({dbg_oe, dbg_pd}, 2'h1);
		for (i = 0; i < 2; i++) begin
			xfer(1'h1, `SCSS_ADDR_PULL2, i);
			repeat (2) @(posedge sys_clk_i);
			ck(ext_pd, !i);
		end
		for (i = 0; i < 4; i++) begin
			xfer(1'h1, `SCSS_ADDR_CLKCFG, i);
			xfer(1'h0, `SCSS_ADDR_CLKCFG, 32'h0);
			ck(q, i);
		end
		xfer(1'h0, 16'h1C10, 32'h0);
		ck(q, 32'h0);
		ck({31'h0, e}, 32'h1);
		sel <= 1'h1;
		repeat (4) @(posedge sys_clk_i);
		ck(ext_sel, 1'h0);
		$display("test select low done");
		rst(1'h1);
		ck({ext_sel, osc_en, ldo_en, dbg_oe}, 4'h9);
		xfer(1'h1, `SCSS_ADDR_CTRL, 32'h6);
		repeat (2) @(posedge sys_clk_i);
		ck({osc_en, ldo_en}, 2'h3);
		xfer(1'h1, `SCSS_ADDR_CLKCFG, 32'h3);
		repeat (2) @(posedge sys_clk_i);
		i = dbg;
		@(posedge sys_clk_i);
		ck(dbg, !i);
		$display("test select high done");
		end_sim;
	end
endmodule : tb
`default_nettype wire
